/* File: hw/lhref_pkg.sv */
// Purpose: constants shared by the limp-home reference register slice
// Assumes: byte-wide register port driven by the serial frame decoder
// Notes:   offsets, field positions and reset values live here only once

package lhref_pkg;

	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int unsigned ADDR_W   = 8;
	localparam int unsigned DATA_W   = 8;
	localparam int unsigned CODE_W   = 10;
	localparam int unsigned LOW_W    = 2;
	localparam int unsigned NUM_CH   = 2;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_RAW_LOW   = 8'h20;
	localparam logic [7:0] ADDR_RAW_HIGH  = 8'h21;
	localparam logic [7:0] ADDR_FILT_LOW  = 8'h22;
	localparam logic [7:0] ADDR_FILT_HIGH = 8'h23;
	localparam logic [7:0] ADDR_CH1_LOW   = 8'h24;
	localparam logic [7:0] ADDR_CH1_HIGH  = 8'h25;
	localparam logic [7:0] ADDR_CH2_LOW   = 8'h26;
	localparam logic [7:0] ADDR_CH2_HIGH  = 8'h27;

	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int unsigned LOW_FIELD_MSB  = 1;
	localparam int unsigned HIGH_CODE_LSB  = 2;
	localparam logic [7:0]  RESERVED_READ  = 8'h00;
	localparam logic [7:0]  SETPOINT_RESET_LOW  = 8'h00;
	localparam logic [7:0]  SETPOINT_RESET_HIGH = 8'h00;
	localparam logic [9:0]  SETTING_RESET       = 10'h000;

	// ------------------------------------------------------------
	// reference scaling
	// ------------------------------------------------------------
	// scale of one code
	localparam int unsigned REF_FULL_SCALE_MV   = 2450;
	localparam int unsigned REF_FULL_SCALE_CODE = 1023;
	localparam logic [9:0]  REF_CODE_MAX        = 10'h3FF;

endpackage : lhref_pkg

/* File: hw/lhref_setpoint_reg.sv */
// Purpose: one channel's ten-bit limp-home current setpoint, split in two bytes
// Assumes: write strobe is already qualified by the clock enable
// Notes:   only bits 1-0 of the low byte are stored
`timescale 1ns/10ps

module lhref_setpoint_reg #(
	parameter logic [7:0] ADDR_LOW  = lhref_pkg::ADDR_CH1_LOW,
	parameter logic [7:0] ADDR_HIGH = lhref_pkg::ADDR_CH1_HIGH
) (
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	input  wire logic       wr_en,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic      [9:0] setpoint
);

	logic [1:0] low_bits;
	logic [7:0] high_bits;
	wire        wr_low  = wr_en && (reg_addr == ADDR_LOW);
	wire        wr_high = wr_en && (reg_addr == ADDR_HIGH);

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			low_bits <= lhref_pkg::SETPOINT_RESET_LOW[1:0];
		end else if (wr_low) begin
			low_bits <= reg_wdata[1:0];
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			high_bits <= lhref_pkg::SETPOINT_RESET_HIGH;
		end else if (wr_high) begin
			high_bits <= reg_wdata;
		end
	end

	assign setpoint = {high_bits, low_bits};

endmodule : lhref_setpoint_reg

/* File: hw/lhref_filt_latch.sv */
// Purpose: holds filtered reference low bits coherent with the last high-byte read
// Assumes: read strobe is already qualified by the clock enable and address
// Notes:   the live low bits are never shown; a stale pair is preferred to a torn one
`timescale 1ns/10ps

module lhref_filt_latch (
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	input  wire logic       rd_high,
	input  wire logic [1:0] filt_low_live,
	output logic      [1:0] filt_low_held
);

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			filt_low_held <= 2'h0;
		end else if (rd_high) begin
			filt_low_held <= filt_low_live;
		end
	end

endmodule : lhref_filt_latch

/* File: hw/lhref_regs.sv */
// Purpose: limp-home reference measurement and setpoint register slice
// Assumes: serial frame decoder on sys_clk gives one-cycle read/write strobes;
//          converter codes arrive on sys_clk from on-chip logic
// Notes:   read data are registered one cycle after the read strobe
`timescale 1ns/10ps

module lhref_regs (
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	input  wire logic       clk_en,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	output logic            reg_rvalid,
	input  wire logic [9:0] raw_ref_code,
	input  wire logic [9:0] filt_ref_code,
	input  wire logic       limp_external_ref_select,
	output logic      [9:0] ch1_limp_current_setpoint,
	output logic      [9:0] ch2_limp_current_setpoint,
	output logic      [9:0] ch1_channel_current_setting,
	output logic      [9:0] ch2_channel_current_setting
);

	// ------------------------------------------------------------
	// strobes
	// ------------------------------------------------------------
	wire rd_en        = reg_rd && clk_en;
	wire wr_en        = reg_wr && clk_en;
	wire hit_raw_low  = (reg_addr == lhref_pkg::ADDR_RAW_LOW);
	wire hit_raw_high = (reg_addr == lhref_pkg::ADDR_RAW_HIGH);
	wire hit_flt_low  = (reg_addr == lhref_pkg::ADDR_FILT_LOW);
	wire hit_flt_high = (reg_addr == lhref_pkg::ADDR_FILT_HIGH);
	wire hit_ch1_low  = (reg_addr == lhref_pkg::ADDR_CH1_LOW);
	wire hit_ch1_high = (reg_addr == lhref_pkg::ADDR_CH1_HIGH);
	wire hit_ch2_low  = (reg_addr == lhref_pkg::ADDR_CH2_LOW);
	wire hit_ch2_high = (reg_addr == lhref_pkg::ADDR_CH2_HIGH);
	// only a filtered high read latches the filtered low bits
	wire rd_flt_high  = rd_en && hit_flt_high;

	// ------------------------------------------------------------
	// setpoint registers, one per channel
	// ------------------------------------------------------------
	logic [9:0] setpoint [lhref_pkg::NUM_CH];

	genvar ch;
	generate
		for (ch = 0; ch < lhref_pkg::NUM_CH; ch = ch + 1) begin : g_ch
			lhref_setpoint_reg #(
				.ADDR_LOW  (ch == 0 ? lhref_pkg::ADDR_CH1_LOW  : lhref_pkg::ADDR_CH2_LOW),
				.ADDR_HIGH (ch == 0 ? lhref_pkg::ADDR_CH1_HIGH : lhref_pkg::ADDR_CH2_HIGH)
			) u_setpoint (
				.sys_clk   (sys_clk),
				.reset_n   (reset_n),
				.wr_en     (wr_en),
				.reg_addr  (reg_addr),
				.reg_wdata (reg_wdata),
				.setpoint  (setpoint[ch])
			);
		end
	endgenerate

	assign ch1_limp_current_setpoint = setpoint[0];
	assign ch2_limp_current_setpoint = setpoint[1];

	// ------------------------------------------------------------
	// configuration check
	// ------------------------------------------------------------
	// the read mux and the two setting outputs are written for two ten-bit channels
	if (lhref_pkg::NUM_CH != 2 || lhref_pkg::CODE_W != 10) begin : g_bad_cfg
		$error("lhref_regs serves two channels of ten-bit codes only");
	end

	// ------------------------------------------------------------
	// filtered low-bit latch
	// ------------------------------------------------------------
	logic [1:0] filt_low_held;

	lhref_filt_latch u_filt_latch (
		.sys_clk       (sys_clk),
		.reset_n       (reset_n),
		.rd_high       (rd_flt_high),
		.filt_low_live (filt_ref_code[1:0]),
		.filt_low_held (filt_low_held)
	);

	// ------------------------------------------------------------
	// read selection
	// ------------------------------------------------------------
	// raw low bits, upper zero
	wire [7:0] val_raw_low  = {6'h00, raw_ref_code[1:0]};
	wire [7:0] val_raw_high = raw_ref_code[9:2];
	wire [7:0] val_flt_low  = {6'h00, filt_low_held};
	wire [7:0] val_flt_high = filt_ref_code[9:2];
	wire [7:0] val_ch1_low  = {6'h00, setpoint[0][1:0]};
	wire [7:0] val_ch2_low  = {6'h00, setpoint[1][1:0]};
	wire [7:0] val_ch1_high = setpoint[0][9:2];
	wire [7:0] val_ch2_high = setpoint[1][9:2];

	// unmapped addresses answer with zero rather than stale data
	wire [7:0] next_reg_rdata =
		hit_raw_low  ? val_raw_low  :
		hit_raw_high ? val_raw_high :
		hit_flt_low  ? val_flt_low  :
		hit_flt_high ? val_flt_high :
		hit_ch1_low  ? val_ch1_low  :
		hit_ch1_high ? val_ch1_high :
		hit_ch2_low  ? val_ch2_low  :
		hit_ch2_high ? val_ch2_high : lhref_pkg::RESERVED_READ;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= lhref_pkg::RESERVED_READ;
		end else if (rd_en) begin
			reg_rdata <= next_reg_rdata;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rvalid <= 1'b0;
		end else if (clk_en) begin
			reg_rvalid <= reg_rd;
		end
	end

	// ------------------------------------------------------------
	// channel current setting in limp-home mode
	// ------------------------------------------------------------
	// external reference overrides
	wire [9:0] next_ch1_setting = limp_external_ref_select ? raw_ref_code : setpoint[0];
	wire [9:0] next_ch2_setting = limp_external_ref_select ? raw_ref_code : setpoint[1];

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ch1_channel_current_setting <= lhref_pkg::SETTING_RESET;
			ch2_channel_current_setting <= lhref_pkg::SETTING_RESET;
		end else if (clk_en) begin
			ch1_channel_current_setting <= next_ch1_setting;
			ch2_channel_current_setting <= next_ch2_setting;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	AST_RAW_LOW_READ: assert property (
		rd_en && hit_raw_low |=> reg_rvalid && reg_rdata == {6'h00, $past(raw_ref_code[1:0])}
	) else $error("raw low read returned wrong data");

	AST_RAW_HIGH_READ: assert property (
		rd_en && hit_raw_high |=> reg_rvalid && reg_rdata == $past(raw_ref_code[9:2])
	) else $error("raw high read returned wrong data");

	AST_FILT_LOW_READ: assert property (
		rd_en && hit_flt_low |=> reg_rdata == {6'h00, $past(filt_low_held)}
	) else $error("filtered low read did not show held bits");

	AST_FILT_HIGH_READ: assert property (
		rd_flt_high |=> reg_rvalid && reg_rdata == $past(filt_ref_code[9:2])
	) else $error("filtered high read returned wrong data");

	AST_FILT_LOW_STABLE: assert property (
		!rd_flt_high |=> filt_low_held == $past(filt_low_held)
	) else $error("filtered low bits changed without a high read");

	// coherent pair after high then low
	AST_FILT_PAIR: assert property (
		rd_flt_high ##1 (rd_en && hit_flt_low) |=>
			reg_rdata[1:0] == $past(filt_ref_code[1:0], 2)
	) else $error("filtered pair not coherent");

	AST_FILT_HIGH_REPEAT: assert property (
		rd_flt_high ##1 rd_flt_high |=> reg_rvalid && reg_rdata == $past(filt_ref_code[9:2])
	) else $error("repeated filtered high read failed");

	AST_CH1_LOW_WRITE: assert property (
		wr_en && hit_ch1_low |=> ch1_limp_current_setpoint[1:0] == $past(reg_wdata[1:0])
			&& ch1_limp_current_setpoint[9:2] == $past(ch1_limp_current_setpoint[9:2])
	) else $error("channel 1 low write not stored");

	AST_CH1_HIGH_WRITE: assert property (
		wr_en && hit_ch1_high |=> ch1_limp_current_setpoint[9:2] == $past(reg_wdata)
	) else $error("channel 1 high write not stored");

	AST_CH2_LOW_WRITE: assert property (
		wr_en && hit_ch2_low |=> ch2_limp_current_setpoint[1:0] == $past(reg_wdata[1:0])
	) else $error("channel 2 low write not stored");

	// channel 2 high write, channel 1 untouched
	AST_CH2_HIGH_WRITE: assert property (
		wr_en && hit_ch2_high |=> ch2_limp_current_setpoint[9:2] == $past(reg_wdata)
			&& ch1_limp_current_setpoint == $past(ch1_limp_current_setpoint)
	) else $error("channel 2 high write not stored");

	AST_LOW_RESERVED_ZERO: assert property (
		rd_en && (hit_ch1_low || hit_ch2_low || hit_flt_low || hit_raw_low)
			|=> reg_rdata[7:2] == 6'h00
	) else $error("reserved low-byte bits not zero");

	AST_CH1_HIGH_READBACK: assert property (
		rd_en && hit_ch1_high |=> reg_rdata == $past(ch1_limp_current_setpoint[9:2])
	) else $error("channel 1 high readback mismatch");

	AST_SETTING_SOURCE: assert property (
		clk_en |=> ch2_channel_current_setting == ($past(limp_external_ref_select)
			? $past(raw_ref_code) : $past(ch2_limp_current_setpoint))
	) else $error("channel setting from wrong source");

	AST_CH1_LOW_READBACK: assert property (
		rd_en && hit_ch1_low |=> reg_rdata == {6'h00, $past(ch1_limp_current_setpoint[1:0])}
	) else $error("channel 1 low readback mismatch");

	AST_CH2_LOW_READBACK: assert property (
		rd_en && hit_ch2_low |=> reg_rdata == {6'h00, $past(ch2_limp_current_setpoint[1:0])}
	) else $error("channel 2 low readback mismatch");

	AST_CH2_HIGH_READBACK: assert property (
		rd_en && hit_ch2_high |=> reg_rdata == $past(ch2_limp_current_setpoint[9:2])
	) else $error("channel 2 high readback mismatch");

	// full-scale code reads back all ones
	AST_RAW_FULL_SCALE: assert property (
		rd_en && hit_raw_high && raw_ref_code == lhref_pkg::REF_CODE_MAX
			|=> reg_rdata == 8'hFF
	) else $error("full-scale reference code not read as all ones");

	// high read captures live low bits
	AST_FILT_LATCH_CAPTURE: assert property (
		rd_flt_high |=> filt_low_held == $past(filt_ref_code[1:0])
	) else $error("filtered low bits not captured at the high read");

	AST_READ_ANSWERED: assert property (
		rd_en |=> reg_rvalid
	) else $error("taken read gave no answer");

	AST_NO_SPURIOUS_ANSWER: assert property (
		clk_en && !reg_rd |=> !reg_rvalid
	) else $error("answer marker raised without a read");

	AST_RDATA_HOLD: assert property (
		!rd_en |=> $stable(reg_rdata)
	) else $error("read data changed without a read");

	AST_RO_WRITE_IGNORED: assert property (
		wr_en && (hit_raw_low || hit_raw_high || hit_flt_low || hit_flt_high)
			|=> $stable(ch1_limp_current_setpoint) && $stable(ch2_limp_current_setpoint)
	) else $error("write to a measurement register changed a setpoint");

	AST_SETPOINT_HOLD: assert property (
		!wr_en |=> $stable(ch1_limp_current_setpoint)
			&& $stable(ch2_limp_current_setpoint)
	) else $error("setpoint changed without a write");

	// channel 1 writes leave channel 2 alone
	AST_CH2_ISOLATED: assert property (
		wr_en && (hit_ch1_low || hit_ch1_high)
			|=> $stable(ch2_limp_current_setpoint)
	) else $error("channel 1 write disturbed channel 2");

	AST_CH1_SETTING_SOURCE: assert property (
		clk_en |=> ch1_channel_current_setting == ($past(limp_external_ref_select)
			? $past(raw_ref_code) : $past(ch1_limp_current_setpoint))
	) else $error("channel 1 setting from wrong source");

	// settings frozen with the clock enable
	AST_SETTING_FREEZE: assert property (
		!clk_en |=> $stable(ch1_channel_current_setting)
			&& $stable(ch2_channel_current_setting)
	) else $error("channel setting moved while the clock enable was low");

	// ------------------------------------------------------------
	// cover points
	// ------------------------------------------------------------
	COV_FILT_HIGH_THEN_LOW: cover property (rd_flt_high ##[1:4] (rd_en && hit_flt_low));
	COV_EXT_SELECT_ON:      cover property (!limp_external_ref_select ##1 limp_external_ref_select);
	COV_CH2_HIGH_WRITE:     cover property (wr_en && hit_ch2_high);
	COV_FILT_HIGH_TWICE:    cover property (rd_flt_high ##1 rd_flt_high);
	COV_RESERVED_WRITE:     cover property (wr_en && hit_ch1_low && reg_wdata[7:2] != 6'h00);

endmodule : lhref_regs

/* File: bench/lhref_host_model.sv */
// Purpose: host side of the register port, one strobe per access
// Assumes: requests launched 1 ns after the rising edge, held one full cycle
// Notes:   address is scrambled after each access so stale values never match
`timescale 1ns/10ps

module lhref_host_model (
	input  wire logic       sys_clk,
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata,
	output logic            reg_wr,
	output logic            reg_rd,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_rvalid
);
	initial begin
		reg_addr  = 8'h00;
		reg_wdata = 8'h00;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
	end

	// -------------------------------------------------------------
	// bus cycles
	// -------------------------------------------------------------
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		#1;
		reg_addr  = a;
		reg_wdata = d;
		reg_wr    = 1'b1;
		@(posedge sys_clk);
		#1;
		reg_wr    = 1'b0;
		reg_addr  = ~a;
		reg_wdata = ~d;
	endtask : wr_reg

	// answer is taken one cycle after the strobe edge, where rvalid stands
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge sys_clk);
		#1;
		reg_addr = a;
		reg_rd   = 1'b1;
		@(posedge sys_clk);
		#1;
		d        = reg_rdata;
		v        = reg_rvalid;
		reg_rd   = 1'b0;
		reg_addr = ~a;
	endtask : rd_reg

	// two reads on consecutive edges; the strobe stays up between them
	task automatic rd_pair(input logic [7:0] a0, input logic [7:0] a1,
		output logic [7:0] d0, output logic [7:0] d1);
		@(posedge sys_clk);
		#1;
		reg_addr = a0;
		reg_rd   = 1'b1;
		@(posedge sys_clk);
		#1;
		d0       = reg_rdata;
		reg_addr = a1;
		@(posedge sys_clk);
		#1;
		d1       = reg_rdata;
		reg_rd   = 1'b0;
		reg_addr = ~a1;
	endtask : rd_pair
endmodule : lhref_host_model

/* File: bench/lhref_regs_tb.sv */
// Purpose: self-checking bench of the limp-home reference register slice
// Assumes: host model issues all accesses; bench drives codes, select, clk_en
// Notes:   expectations are built from the package offsets and fixed codes
`timescale 1ns/10ps

module lhref_regs_tb;
	localparam int LIMIT = 5000;
	logic       sys_clk;
	logic       reset_n;
	logic       clk_en;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_rdata;
	logic       reg_rvalid;
	logic [9:0] raw_ref_code;
	logic [9:0] filt_ref_code;
	logic       sel;
	logic [9:0] sp1;
	logic [9:0] sp2;
	logic [9:0] set1;
	logic [9:0] set2;
	int         err_count;
	int         n_checks;
	int         cycles;

	lhref_host_model host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

	lhref_regs uut (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .raw_ref_code(raw_ref_code),
		.filt_ref_code(filt_ref_code), .limp_external_ref_select(sel),
		.ch1_limp_current_setpoint(sp1), .ch2_limp_current_setpoint(sp2),
		.ch1_channel_current_setting(set1), .ch2_channel_current_setting(set2));

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	// -------------------------------------------------------------
	// checking helpers
	// -------------------------------------------------------------
	task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic       v;
		host.rd_reg(a, d, v);
		chk("rvalid", 10'h001, {9'h000, v});
		chk($sformatf("rdata at %h", a), {2'b00, exp}, {2'b00, d});
	endtask : rd_chk

	task automatic end_of_test();
		if (err_count == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_of_test

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			err_count++;
			end_of_test();
		end
	end

	// -------------------------------------------------------------
	// scenarios
	// -------------------------------------------------------------
	task automatic t_reset();
		chk("sp1", 10'h000, sp1);
		chk("sp2", 10'h000, sp2);
		rd_chk(lhref_pkg::ADDR_CH1_LOW, 8'h00);
		rd_chk(lhref_pkg::ADDR_CH2_HIGH, 8'h00);
		rd_chk(8'h30, 8'h00);
	endtask : t_reset

	task automatic t_raw();
		raw_ref_code = 10'h2D6;
		host.wr_reg(lhref_pkg::ADDR_RAW_HIGH, 8'h11);
		rd_chk(lhref_pkg::ADDR_RAW_LOW, 8'h02);
		rd_chk(lhref_pkg::ADDR_RAW_HIGH, 8'hB5);
		raw_ref_code = 10'h3FF;
		rd_chk(lhref_pkg::ADDR_RAW_HIGH, 8'hFF);
	endtask : t_raw

	// low bits must come from the code seen at the high read, not the live one
	task automatic t_filt();
		logic [7:0] d0;
		logic [7:0] d1;
		filt_ref_code = 10'h1B7;
		rd_chk(lhref_pkg::ADDR_FILT_HIGH, 8'h6D);
		filt_ref_code = 10'h0C8;
		rd_chk(lhref_pkg::ADDR_FILT_LOW, 8'h03);
		rd_chk(lhref_pkg::ADDR_FILT_HIGH, 8'h32);
		filt_ref_code = 10'h0C9;
		rd_chk(lhref_pkg::ADDR_FILT_HIGH, 8'h32);
		rd_chk(lhref_pkg::ADDR_FILT_LOW, 8'h01);
		// back to back: repeated high reads, then a high read straight into a low read
		filt_ref_code = 10'h2EA;
		host.rd_pair(lhref_pkg::ADDR_FILT_HIGH, lhref_pkg::ADDR_FILT_HIGH, d0, d1);
		chk("filt high first", 10'h0BA, {2'b00, d0});
		chk("filt high again", 10'h0BA, {2'b00, d1});
		filt_ref_code = 10'h155;
		host.rd_pair(lhref_pkg::ADDR_FILT_HIGH, lhref_pkg::ADDR_FILT_LOW, d0, d1);
		chk("filt pair high", 10'h055, {2'b00, d0});
		chk("filt pair low", 10'h001, {2'b00, d1});
	endtask : t_filt

	task automatic t_setpoints();
		host.wr_reg(lhref_pkg::ADDR_CH1_LOW, 8'hFF);
		rd_chk(lhref_pkg::ADDR_CH1_LOW, 8'h03);
		host.wr_reg(lhref_pkg::ADDR_CH1_HIGH, 8'hA5);
		rd_chk(lhref_pkg::ADDR_CH1_HIGH, 8'hA5);
		chk("sp1", 10'h297, sp1);
		host.wr_reg(lhref_pkg::ADDR_CH2_LOW, 8'hFE);
		host.wr_reg(lhref_pkg::ADDR_CH2_HIGH, 8'h5C);
		rd_chk(lhref_pkg::ADDR_CH2_LOW, 8'h02);
		rd_chk(lhref_pkg::ADDR_CH2_HIGH, 8'h5C);
		chk("sp2", 10'h172, sp2);
		chk("sp1", 10'h297, sp1);
	endtask : t_setpoints

	task automatic t_select();
		raw_ref_code = 10'h155;
		sel = 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		chk("set1", 10'h297, set1);
		chk("set2", 10'h172, set2);
		sel = 1'b1;
		// the setting is registered once, so one edge is enough
		@(posedge sys_clk);
		#1;
		chk("set1", 10'h155, set1);
		chk("set2", 10'h155, set2);
		sel = 1'b0;
	endtask : t_select

	// a frozen clock enable must drop the write
	task automatic t_freeze();
		@(posedge sys_clk);
		#1;
		clk_en = 1'b0;
		host.wr_reg(lhref_pkg::ADDR_CH1_HIGH, 8'h0F);
		clk_en = 1'b1;
		chk("sp1", 10'h297, sp1);
	endtask : t_freeze

	// a reset in mid-run must clear setpoints, the channel 1 setting and the filtered latch
	task automatic t_reset_again();
		@(posedge sys_clk);
		#1;
		reset_n = 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		reset_n = 1'b1;
		chk("sp1", 10'h000, sp1);
		chk("sp2", 10'h000, sp2);
		chk("set1", 10'h000, set1);
		rd_chk(lhref_pkg::ADDR_FILT_LOW, 8'h00);
		rd_chk(lhref_pkg::ADDR_CH2_LOW, 8'h00);
	endtask : t_reset_again

	initial begin
		err_count     = 0;
		n_checks      = 0;
		cycles        = 0;
		reset_n       = 1'b0;
		clk_en        = 1'b1;
		raw_ref_code  = 10'h000;
		filt_ref_code = 10'h000;
		sel           = 1'b0;
		repeat (10) @(posedge sys_clk);
		#1;
		reset_n = 1'b1;
		t_reset();
		t_raw();
		t_filt();
		t_setpoints();
		t_select();
		t_freeze();
		t_reset_again();
		end_of_test();
	end
endmodule : lhref_regs_tb
